// *** hw/dts_cfg.svh ***
// constants for the termination select block
`ifndef DTS_CFG_SVH
`define DTS_CFG_SVH
`define DTS_CODE_W 3
`define DTS_CODE_OFF 3'h0
`define DTS_LAT_W 6
`define DTS_PRE1_START_SUB 6'h02
`define DTS_PRE2_START_SUB 6'h03
`define DTS_WIN_BASE 6'h02
`define DTS_DEF_READ_LATENCY 6'h10
`define DTS_DEF_BURST_LENGTH 6'h08
`define DTS_DEF_TERM_DELAY 6'h07
`define DTS_DEF_WRITE_LATENCY 6'h09
`define DTS_DEF_WRITE_LEN 6'h06
`endif

// *** hw/dts_pkg.sv ***
// types for the termination select block
package dts_pkg;
	typedef enum logic [1:0] {
		dts_off,
		dts_write,
		dts_nominal,
		dts_parked
	} dts_state_type;
	typedef struct packed {
		logic [2:0] nominal_code;
		logic [2:0] write_code;
		logic [2:0] parked_code;
	} dts_codes_type;
	typedef struct packed {
		dts_state_type state;
		logic [2:0] code;
	} dts_term_type;
endpackage : dts_pkg

// *** hw/dts_term_select.sv ***
// on-die termination state selection inside the memory device
// Operation
// (R1) one of four termination states at all times
// (R2) non-zero mode fields enable, code gives value
// (R3) write termination during write, pin ignored
// (R4) pin high turns on nominal unless disabled
// (R5) parked is default when nominal inactive
// (R6) priority: read off, write, nominal, parked
// (R7) read forces high impedance for window
// (R8) write command enables write termination period
// (R9) nominal disabled powers down pin receiver
// (R10) self refresh switches all termination off
// (R11) read off starts latency minus two/three
// (R12) window half burst plus two, three, four
// (R13) pin ignored when nominal off or refresh
// (R14) nominal follows pin after on/off delay
// (R15) state re-evaluated every rising clock edge; the code holds state on edges where clk_en is low
// (R16) controller drives pin defined while enabled
`timescale 1ns/10ps
`include "dts_cfg.svh"
module dts_term_select #(
	parameter int LW = `DTS_LAT_W
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic termination_control_pin,
	input wire logic read_cmd,
	input wire logic write_cmd,
	input wire logic self_refresh,
	input wire logic [2:0] mode_reg_one_nominal,
	input wire logic [2:0] mode_reg_two_write,
	input wire logic [2:0] mode_reg_five_parked,
	input wire logic preamble_two,
	input wire logic write_crc_en,
	input wire logic [LW-1:0] read_latency,
	input wire logic [LW-1:0] burst_length,
	input wire logic [LW-1:0] direct_term_on_delay,
	input wire logic [LW-1:0] direct_term_off_delay,
	input wire logic [LW-1:0] write_term_delay,
	input wire logic [LW-1:0] write_term_len,
	output logic [1:0] term_state,
	output logic [2:0] term_code,
	output logic term_enabled,
	output logic pin_rx_power
);
	localparam int DEPTH = 1 << LW;
	// start offsets and base length sized to the counter width
	localparam logic [LW-1:0] PRE1_SUB = LW'(`DTS_PRE1_START_SUB);
	localparam logic [LW-1:0] PRE2_SUB = LW'(`DTS_PRE2_START_SUB);
	localparam logic [LW-1:0] WIN_BASE = LW'(`DTS_WIN_BASE);

	logic pin_meta_ff, pin_sync_ff;
	logic [DEPTH-1:0] pin_hist_ff, nxt_pin_hist;
	logic nom_on_ff, nxt_nom_on;
	logic [LW-1:0] rd_wait_ff, nxt_rd_wait, rd_win_ff, nxt_rd_win;
	logic [LW-1:0] wr_wait_ff, nxt_wr_wait, wr_win_ff, nxt_wr_win;
	logic [1:0] state_ff, nxt_state;
	logic [2:0] code_ff, nxt_code;
	logic en_ff, nxt_en, rx_ff, nxt_rx;
	logic nom_en, wr_en, park_en, pin_live;
	logic rd_active, wr_active, nom_active;
	dts_pkg::dts_codes_type codes;

	// counters hold at zero instead of wrapping
	function automatic logic [LW-1:0] dec_sat(input logic [LW-1:0] v);
		dec_sat = (v == '0) ? '0 : LW'(v - 1'b1);
	endfunction : dec_sat

	// mode fields travel together as one carrier
	always_comb begin
		codes.nominal_code = mode_reg_one_nominal;
		codes.write_code = mode_reg_two_write;
		codes.parked_code = mode_reg_five_parked;
	end
	assign nom_en = codes.nominal_code != `DTS_CODE_OFF; // R2
	assign wr_en = codes.write_code != `DTS_CODE_OFF; // R2
	assign park_en = codes.parked_code != `DTS_CODE_OFF; // R2
	// receiver off and pin ignored if nominal off or in self refresh
	assign pin_live = nom_en && !self_refresh; // R13 R9

	// the write window and nominal flag only count while their mode fields allow it; the read window is not gated
	assign rd_active = rd_win_ff != '0; // R7
	assign wr_active = wr_win_ff != '0 && wr_en; // R3
	// nominal needs a live pin now, not only the delayed flag
	assign nom_active = nom_on_ff && pin_live; // R4 R13

	// two-stage sync; only the second stage feeds logic
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pin_meta_ff <= 1'b0;
			pin_sync_ff <= 1'b0;
		end else if (clk_en) begin
			pin_meta_ff <= termination_control_pin;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// pin history shift; delayed taps give on/off latencies
	always_comb begin
		nxt_pin_hist = {pin_hist_ff[DEPTH-2:0], pin_sync_ff && pin_live};
		nxt_nom_on = nom_on_ff;
		if (!pin_live)
			nxt_nom_on = 1'b0; // R13
		else if (!nom_on_ff && pin_hist_ff[direct_term_on_delay])
			nxt_nom_on = 1'b1; // R14 R4
		else if (nom_on_ff && !pin_hist_ff[direct_term_off_delay])
			nxt_nom_on = 1'b0; // R14
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pin_hist_ff <= '0;
			nom_on_ff <= 1'b0;
		end else if (clk_en) begin
			pin_hist_ff <= nxt_pin_hist;
			nom_on_ff <= nxt_nom_on;
		end
	end

	// read and write windows; a new command reloads its wait, or its window directly when the delay is too short
	always_comb begin
		logic [LW-1:0] sub, len;
		sub = preamble_two ? PRE2_SUB : PRE1_SUB; // R11
		len = LW'((burst_length >> 1) + WIN_BASE
			+ LW'(preamble_two) + LW'(write_crc_en)); // R12
		nxt_rd_wait = dec_sat(rd_wait_ff);
		nxt_rd_win = rd_win_ff;
		if (rd_wait_ff == LW'(1))
			nxt_rd_win = len;
		else if (rd_win_ff != '0)
			nxt_rd_win = dec_sat(rd_win_ff);
		if (read_cmd) begin
			// start when wait reaches zero: read_latency - sub cycles
			if (read_latency > sub + LW'(1)) begin
				nxt_rd_wait = LW'(read_latency - sub); // R11
			end else begin
				nxt_rd_wait = '0;
				nxt_rd_win = len;
			end
		end

		// write window: same count-then-hold scheme
		nxt_wr_wait = dec_sat(wr_wait_ff);
		nxt_wr_win = wr_win_ff;
		if (wr_wait_ff == LW'(1))
			nxt_wr_win = write_term_len;
		else if (wr_win_ff != '0)
			nxt_wr_win = dec_sat(wr_win_ff);
		if (write_cmd && wr_en) begin
			if (write_term_delay > LW'(1))
				nxt_wr_wait = write_term_delay; // R8
			else
				nxt_wr_win = write_term_len;
		end

		// no window may survive into or fire after self refresh
		if (self_refresh) begin
			nxt_rd_wait = '0;
			nxt_rd_win = '0;
			nxt_wr_wait = '0;
			nxt_wr_win = '0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rd_wait_ff <= '0;
			rd_win_ff <= '0;
			wr_wait_ff <= '0;
			wr_win_ff <= '0;
		end else if (clk_en) begin
			rd_wait_ff <= nxt_rd_wait;
			rd_win_ff <= nxt_rd_win;
			wr_wait_ff <= nxt_wr_wait;
			wr_win_ff <= nxt_wr_win;
		end
	end

	// resolved state, recomputed each clk_en edge from registered window and nominal flags plus live mode and refresh inputs
	always_comb begin
		nxt_state = dts_pkg::dts_off; // R1
		nxt_code = `DTS_CODE_OFF;
		if (self_refresh) begin
			nxt_state = dts_pkg::dts_off; // R10
		end else if (rd_active) begin
			nxt_state = dts_pkg::dts_off; // R7 R6
		end else if (wr_active) begin
			nxt_state = dts_pkg::dts_write; // R3 R6
			nxt_code = codes.write_code;
		end else if (nom_active) begin
			nxt_state = dts_pkg::dts_nominal; // R4 R6
			nxt_code = codes.nominal_code;
		end else if (park_en) begin
			nxt_state = dts_pkg::dts_parked; // R5 R6
			nxt_code = codes.parked_code;
		end
		nxt_en = (nom_en || wr_en || park_en) && !self_refresh; // R2
		nxt_rx = pin_live; // R9
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_ff <= 2'h0;
			code_ff <= `DTS_CODE_OFF;
			en_ff <= 1'b0;
			rx_ff <= 1'b0;
		end else if (clk_en) begin
			state_ff <= nxt_state; // R15
			code_ff <= nxt_code;
			en_ff <= nxt_en;
			rx_ff <= nxt_rx;
		end
	end

	// ports are plain copies of the registers
	assign term_state = state_ff;
	assign term_code = code_ff;
	assign term_enabled = en_ff;
	assign pin_rx_power = rx_ff;
endmodule : dts_term_select

// *** tb/dts_term_select_props.sv ***
// assertions for the termination select block
`timescale 1ns/10ps
module dts_term_select_props (
	input wire logic clock,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic read_cmd,
	input wire logic write_cmd,
	input wire logic self_refresh,
	input wire logic [2:0] mode_reg_one_nominal,
	input wire logic [2:0] mode_reg_two_write,
	input wire logic [2:0] mode_reg_five_parked,
	input wire logic preamble_two,
	input wire logic write_crc_en,
	input wire logic [1:0] term_state,
	input wire logic [2:0] term_code,
	input wire logic term_enabled,
	input wire logic pin_rx_power
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// windows assume read latency 16, burst 8, write delay 7, length 6
	sequence s_rd_short;
		read_cmd && clk_en && !preamble_two && !write_crc_en;
	endsequence
	sequence s_rd_long;
		read_cmd && clk_en && preamble_two && write_crc_en;
	endsequence
	sequence s_wr_on;
		(term_state == 2'h1 && term_code == mode_reg_two_write)[*6];
	endsequence
	property p_rd_short;
		s_rd_short |-> ##16 (term_state == 2'h0)[*6];
	endproperty
	property p_rd_long;
		s_rd_long |-> ##15 (term_state == 2'h0)[*8];
	endproperty
	property p_wr;
		write_cmd && clk_en && mode_reg_two_write != 3'h0 |-> ##9 s_wr_on;
	endproperty
	property p_wr_off;
		write_cmd && mode_reg_two_write == 3'h0 |-> ##9 term_state != 2'h1;
	endproperty
	property p_en;
		clk_en && !self_refresh && (|{mode_reg_one_nominal,
			mode_reg_five_parked}) |=> term_enabled;
	endproperty
	property p_rx;
		clk_en && mode_reg_one_nominal == 3'h0 |=> !pin_rx_power;
	endproperty
	property p_sr;
		clk_en && self_refresh |=> term_state == 2'h0 && !term_enabled;
	endproperty
	property p_park;
		term_state == 2'h3 && $past(clk_en) |->
			term_code == $past(mode_reg_five_parked);
	endproperty
	property p_nom;
		term_state == 2'h2 && $past(clk_en) |->
			term_code == $past(mode_reg_one_nominal) && term_code != 3'h0;
	endproperty
	a_rd_short: assert property (p_rd_short) else $error("read off short");
	a_rd_long: assert property (p_rd_long) else $error("read off long");
	a_wr: assert property (p_wr) else $error("write window wrong");
	a_wr_off: assert property (p_wr_off) else $error("write not refused");
	a_en: assert property (p_en) else $error("enable missing");
	a_rx: assert property (p_rx) else $error("receiver powered");
	a_sr: assert property (p_sr) else $error("refresh not off");
	a_park: assert property (p_park) else $error("parked code wrong");
	a_nom: assert property (p_nom) else $error("nominal code wrong");
endmodule : dts_term_select_props
bind dts_term_select dts_term_select_props chk_u (.*);

// *** tb/dts_ctrl_model.sv ***
// controller model driving the pin and the commands
`timescale 1ns/10ps
module dts_ctrl_model (
	input wire logic clock,
	output logic pin,
	output logic rd,
	output logic wr
);
	// pin always held at a defined level
	initial begin
		pin = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
	end
	task automatic drive(input logic v);
		@(negedge clock);
		pin = v;
	endtask : drive
	task automatic cmd(input logic r, input logic w);
		@(negedge clock);
		rd = r;
		wr = w;
		@(negedge clock);
		rd = 1'b0;
		wr = 1'b0;
	endtask : cmd
endmodule : dts_ctrl_model

// *** tb/tb_dts_term_select.sv ***
// testbench for the termination select block
`timescale 1ns/10ps
module tb_dts_term_select;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic sr = 1'b0;
	logic ce = 1'b1;
	logic p2 = 1'b0;
	logic crc = 1'b0;
	logic [2:0] nom = 3'h0;
	logic [2:0] wrc = 3'h0;
	logic [2:0] prk = 3'h0;
	logic [5:0] rl = 6'h10;
	logic [5:0] bl = 6'h08;
	logic [5:0] dly = 6'h07;
	logic [5:0] wl = 6'h06;
	logic [1:0] st, es;
	logic [2:0] cd, ec;
	logic en, rxp, pin, rd, wr;
	int errors = 0;
	int n_compared = 0;
	always #4 clock = ~clock;
	dts_ctrl_model ctl_u (.clock(clock), .pin(pin), .rd(rd), .wr(wr));
	dts_term_select dut_u (.clock(clock), .nrst(nrst), .clk_en(ce),
		.termination_control_pin(pin), .read_cmd(rd), .write_cmd(wr),
		.self_refresh(sr), .mode_reg_one_nominal(nom),
		.mode_reg_two_write(wrc), .mode_reg_five_parked(prk),
		.preamble_two(p2), .write_crc_en(crc), .read_latency(rl),
		.burst_length(bl), .direct_term_on_delay(dly),
		.direct_term_off_delay(dly), .write_term_delay(dly),
		.write_term_len(wl), .term_state(st), .term_code(cd),
		.term_enabled(en), .pin_rx_power(rxp));
	task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic complete_run;
		$display("compared=%0d errors=%0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run
	task automatic rd_win(input int s, input int n);
		ctl_u.cmd(1'b1, 1'b0);
		repeat (s - 1) @(negedge clock);
		chk({st, cd}, 7'h12);
		@(negedge clock);
		chk({st, cd}, 7'h00);
		repeat (n - 1) @(negedge clock);
		chk({st, cd}, 7'h00);
		@(negedge clock);
		chk({st, cd}, 7'h12);
	endtask : rd_win
	initial begin
		repeat (2) @(negedge clock);
		chk({st, cd, en, rxp}, 7'h00);
		nrst = 1'b1;
		// every park, nominal and pin combination with writes disabled
		for (int i = 0; i < 8; i++) begin
			prk = i[0] ? 3'h4 : 3'h0;
			nom = i[1] ? 3'h2 : 3'h0;
			ctl_u.drive(i[2]);
			repeat (20) @(negedge clock);
			es = (i[1] && i[2]) ? 2'h2 : (i[0] ? 2'h3 : 2'h0);
			ec = (es == 2'h2) ? nom : ((es == 2'h3) ? prk : 3'h0);
			chk({st, cd, en, rxp}, {es, ec, |{nom, prk}, |nom});
		end
		wrc = 3'h1;
		ctl_u.cmd(1'b0, 1'b1);
		repeat (8) @(negedge clock);
		chk({st, cd}, 7'h09);
		repeat (6) @(negedge clock);
		chk({st, cd}, 7'h12);
		rd_win(15, 6);
		p2 = 1'b1;
		crc = 1'b1;
		rd_win(14, 8);
		wrc = 3'h0;
		ctl_u.cmd(1'b0, 1'b1);
		repeat (8) @(negedge clock);
		chk({st, cd}, 7'h12);
		ce = 1'b0;
		nom = 3'h0;
		repeat (3) @(negedge clock);
		chk({st, cd, en, rxp}, 7'h4b);
		ce = 1'b1;
		@(negedge clock);
		chk({st, cd, en, rxp}, 7'h72);
		sr = 1'b1;
		repeat (2) @(negedge clock);
		chk({st, cd, en, rxp}, 7'h00);
		complete_run();
	end
endmodule : tb_dts_term_select
